// File: bench/osc_model.sv
// Oscillator source model: ready levels and the external, low and mid clock levels.
// Assumes the clock switch block drives the run requests and the frequency select.
`timescale 1ns/10ps
module osc_model (
  input  wire clksw_pkg::osc_vec_t osc_enable,   // Run requests
  input  wire logic                pclk,         // Bus clock
  input  wire logic                presetn,      // Reset, active low
  input  wire logic [2:0]          frq_sel,      // Frequency select
  input  wire logic                ext_stop,     // Stalls the external clock high
  output clksw_pkg::osc_vec_t      osc_ready_in, // Ready levels
  output logic                     ext_clk_in,   // External clock level
  output logic                     lf_clk_in,    // Low clock level
  output logic                     mf_clk_in     // Raw mid clock level
);
  import clksw_pkg::*;
  logic [3:0]      cnt_q;
  logic [3:0][5:0] en_q;
  logic [2:0]      frq_q;
  logic [3:0]      gap_q;
  logic            hf_ok;
  // Ready lags the request by four cycles, so a switch never completes in the request cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cnt_q, en_q, frq_q, gap_q} <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      en_q  <= {en_q[2:0], osc_enable};
      frq_q <= frq_sel;
      gap_q <= (frq_q != frq_sel) ? 4'hF : gap_q - {3'h0, gap_q != 4'h0};
    end
  end
  // A frequency change knocks the internal oscillator out for fifteen cycles
  assign hf_ok        = gap_q == 4'h0;
  assign osc_ready_in = en_q[3] & {1'b1, hf_ok, hf_ok, 3'b111};
  // A stopped crystal is stuck high and gives no falling edges
  assign ext_clk_in   = (cnt_q[1] & osc_enable.ext) | ext_stop;
  assign lf_clk_in    = cnt_q[3];
  assign mf_clk_in    = cnt_q[0];
endmodule : osc_model

// File: bench/tb.sv
// Self-checking bench for the clock switch and fail-safe monitor.
// Assumes the oscillator model on the far side and drives APB from here.
`timescale 1ns/10ps
`include "clksw_cfg.svh"
module tb;
  import clksw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_stop, fs_en, doze;
  logic        sleep_enter, wake, halt, force_1m, mf_clk, sw_irq, fail_irq, ext_clk, lf_clk, mf_raw, v;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  frq;
  osc_vec_t    ready, osc_en;
  clk_sel_t    sel;
  int          error_cnt, checks, exp_req, exp_cur;
  int          bad [3] = '{32'h00, 32'h30, 32'h6A};
  clock_switch_failsafe_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_ready_in(ready), .ext_clk_in(ext_clk), .lf_clk_in(lf_clk), .mf_clk_in(mf_raw),
    .failsafe_enable_cfg(fs_en), .external_clock_input_mode(1'b0), .doze_active(doze),
    .sleep_enter(sleep_enter), .wake(wake), .osc_enable(osc_en), .sys_clk_sel(sel), .sys_clk_halt(halt),
    .hf_force_1mhz(force_1m), .hf_frequency_select(frq), .mf_derived_clock(mf_clk), .switch_irq(sw_irq),
    .osc_fail_irq(fail_irq));
  osc_model i_osc (.osc_enable(osc_en), .pclk(pclk), .presetn(presetn), .frq_sel(frq), .ext_stop(ext_stop),
    .osc_ready_in(ready), .ext_clk_in(ext_clk), .lf_clk_in(lf_clk), .mf_clk_in(mf_raw));
  // Clock of 10 ns
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    doze   <= 1'($urandom_range(1, 0));
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rd & mask, exp);
  endtask : rdchk
  // Reference of the request register: reserved codes leave it untouched
  task automatic wr_req(input int val);
    apb(1'b1, `IDX_REQUEST, val);
    if (val[6:4] != 0 && val[6:4] != 3 && val[3:0] <= 9) exp_req = val;
  endtask : wr_req
  task automatic wait_cur(input int exp, input int maxc);
    int n;
    n = 0;
    while (sel !== exp[6:0] && n < maxc) begin
      @(posedge pclk);
      n++;
    end
    chk("current sel", {25'h0, sel}, exp);
    exp_cur = exp;
  endtask : wait_cur
  task automatic results();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Watchdog well beyond the two start-up waits
  initial begin
    #300000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(32'h03CE5A69));
    {presetn, psel, penable, pwrite, ext_stop, fs_en, doze, sleep_enter, wake} = '0;
    {paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    exp_req = 32'h62;
    exp_cur = 32'h62;
    rdchk(`IDX_REQUEST, 32'h62, 32'hFF);
    rdchk(`IDX_SW_CTRL, 32'h10, 32'hFF);
    apb(1'b1, `IDX_CURRENT, 32'h7F);
    rdchk(`IDX_CURRENT, 32'h62, 32'hFF);
    apb(1'b0, 12'h8FF, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr_req(bad[i] | (i < 2 ? $urandom_range(9, 0) : $urandom_range(5, 0)));
      rdchk(`IDX_REQUEST, exp_req, 32'hFF);
    end
    apb(1'b1, `IDX_IRQ_EN, 32'h3);
    // Divider-only changes switch at once and raise the flag
    repeat (3) begin
      wr_req(32'h60 | ((exp_req % 16 + 1 + $urandom_range(8, 0)) % 10));
      wait_cur(exp_req, 20);
      chk("switch irq", {31'h0, sw_irq}, 32'h1);
      rdchk(`IDX_SW_CTRL, 32'h10, 32'h18);
      rdchk(`IDX_IRQ_FLAG, 32'h1, 32'h1);
      apb(1'b1, `IDX_IRQ_FLAG, 32'h1);
    end
    // Held switch, released by clearing the hold
    apb(1'b1, `IDX_SW_CTRL, 32'h80);
    wr_req(32'h50);
    repeat (12) @(posedge pclk);
    chk("held sel", {25'h0, sel}, exp_cur);
    rdchk(`IDX_SW_CTRL, 32'h88, 32'h98);
    rdchk(`IDX_IRQ_FLAG, 32'h1, 32'h1);
    apb(1'b1, `IDX_SW_CTRL, 32'h0);
    wait_cur(exp_req, 20);
    // Abandoned switch leaves the flag set
    apb(1'b1, `IDX_SW_CTRL, 32'h80);
    wr_req(32'h40);
    repeat (12) @(posedge pclk);
    wr_req(exp_cur);
    rdchk(`IDX_SW_CTRL, 32'h10, 32'h18);
    rdchk(`IDX_IRQ_FLAG, 32'h1, 32'h1);
    chk("abandon sel", {25'h0, sel}, exp_cur);
    apb(1'b1, `IDX_SW_CTRL, 32'h0);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h1);
    // Sleep before the slow source is ready, then wake
    wr_req(32'h40);
    @(posedge pclk);
    sleep_enter <= 1'b1;
    @(posedge pclk);
    sleep_enter <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("sleep sel", {25'h0, sel}, exp_cur);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    wait_cur(exp_req, 10);
    rdchk(`IDX_IRQ_FLAG, 32'h1, 32'h1);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h1);
    // Manual enables, then a frequency change
    apb(1'b1, `IDX_ENABLE, 32'h60);
    chk("manual enable", {30'h0, osc_en.hf, osc_en.mf}, 32'h3);
    repeat (8) @(posedge pclk);
    apb(1'b1, `IDX_FRQ_SEL, 32'h3);
    v = mf_clk;
    repeat (3) @(posedge pclk);
    chk("mf frozen", {31'h0, mf_clk}, {31'h0, v});
    rdchk(`IDX_STATUS, 32'h0, 32'h60);
    repeat (30) @(posedge pclk);
    rdchk(`IDX_STATUS, 32'h60, 32'h60);
    // Fail-safe: crystal start-up, stall, fallback, return
    fs_en <= 1'b1;
    wr_req(32'h70);
    wait_cur(exp_req, 6000);
    rdchk(`IDX_STATUS, 32'h80, 32'h80);
    ext_stop <= 1'b1;
    wait_cur(32'h60, 2000);
    chk("force 1mhz", {31'h0, force_1m}, 32'h1);
    chk("fail irq", {31'h0, fail_irq}, 32'h1);
    repeat (300) @(posedge pclk);
    chk("fail sel", {25'h0, sel}, 32'h60);
    apb(1'b1, `IDX_IRQ_FLAG, 32'h2);
    ext_stop <= 1'b0;
    wr_req(32'h71);
    wait_cur(exp_req, 6000);
    chk("force cleared", {31'h0, force_1m}, 32'h0);
    rdchk(`IDX_IRQ_FLAG, 32'h0, 32'h2);
    results();
  end
endmodule : tb

// File: common/clksw_cfg.svh
// Constants of the clock switch and fail-safe monitor: offsets, fields, resets, counts.
// Assumes one clock domain (pclk at 100 MHz) and a 32-bit APB register port.
// Function
// - Per-oscillator ready status and manual enables.
// - Frequency select write clears high/mid ready.
// - Mid clock freezes while frequency change pends.
// - Three-bit source codes, reserved writes ignored.
// - Four-bit divider, power of two up to 512.
// - Keep old clock until requested source ready.
// - Same source or divider-only: ready at once.
// - Ready sets new-ready and switch flag together.
// - Hold clear: switch as soon as ready.
// - Hold set: wait; software releases or abandons.
// - Reduced-rate CPU: switch on next cycle.
// - Current fields update at switch; done set.
// - PLL input change halts clock until lock.
// - PLL lock failure triggers fail-safe.
// - Sleep drops switch; wake completes or re-requests.
// - Switch flag never cleared by hardware.
// - Monitor only when enabled, all external modes.
// - Sample clock is low clock over 64.
// - Failure: internal 1 MHz, set fail flag.
// - Stay internal until software requests return.
// - Fail condition clears on reset, sleep, request.
// - Fail flag set again if failure persists.
// - Detection only after start-up timer expires, or at once in external clock input mode.
// - Start-up timer counts 1024 oscillator cycles.
`ifndef CLKSW_CFG_SVH
`define CLKSW_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_REQUEST   12'h88D
`define IDX_CURRENT   12'h88E
`define IDX_SW_CTRL   12'h88F
`define IDX_STATUS    12'h890
`define IDX_ENABLE    12'h891
`define IDX_FRQ_SEL   12'h893
`define IDX_IRQ_FLAG  12'h8A0
`define IDX_IRQ_EN    12'h8A1
// Field positions and the divider limit
`define REQ_SRC_LSB   4
`define REQ_DIV_MAX   4'h9
`define CTL_HOLD      7
`define CTL_DONE      4
`define CTL_NEWRDY    3
`define IRQ_SWITCH    0
`define IRQ_OSCFAIL   1
// Source codes
`define SRC_EXT       3'h7
`define SRC_HF        3'h6
`define SRC_LF        3'h5
`define SRC_SEC       3'h4
`define SRC_EXT_PLL   3'h2
`define SRC_HF_PLL    3'h1
// Reset values and the fail-safe divider
`define RST_SRC       3'h6
`define RST_DIV       4'h2
`define RST_FRQ       3'h0
`define FS_DIV        4'h0
// Timing counts
`define OST_CYCLES    1024
`define SAMPLE_DIV    64
`endif

// File: common/clksw_pkg.sv
// Types shared by the clock switch logic.
// Assumes clksw_cfg.svh for the numeric constants.
package clksw_pkg;
  // Oscillator ready inputs / enable outputs, bit order as in the status register
  typedef struct packed {
    logic ext;
    logic hf;
    logic mf;
    logic lf;
    logic sec;
    logic pll;
  } osc_vec_t;

  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } clk_sel_t;

  typedef enum logic [3:0] {
    SW_IDLE = 4'h1,
    SW_WAIT = 4'h2,
    SW_HOLD = 4'h4,
    SW_LOCK = 4'h8
  } sw_state_t;
endpackage : clksw_pkg

// File: logic/clock_switch_failsafe_monitor.sv
// Clock source request, glitch-free switch sequencing and fail-safe clock monitor.
// Assumes all inputs synchronous to pclk; oscillators report ready levels; registers on APB.
`timescale 1ns/10ps
`include "clksw_cfg.svh"
module clock_switch_failsafe_monitor (
  input  wire logic              pclk,              // Bus and logic clock
  input  wire logic              presetn,           // Asynchronous reset, active low
  input  wire logic              psel,              // APB select
  input  wire logic              penable,           // APB access phase
  input  wire logic              pwrite,            // APB direction
  input  wire logic [13:0]       paddr,             // APB byte address
  input  wire logic [31:0]       pwdata,            // APB write data
  output logic      [31:0]       prdata,            // APB read data
  output logic                   pready,            // APB ready
  output logic                   pslverr,           // APB error on unmapped address
  input  wire clksw_pkg::osc_vec_t osc_ready_in,    // Ready levels from oscillators
  input  wire logic              ext_clk_in,        // External clock level, sampled
  input  wire logic              lf_clk_in,         // Low-frequency internal clock level
  input  wire logic              mf_clk_in,         // Raw mid-frequency clock
  input  wire logic              failsafe_enable_cfg, // Monitor enable strap
  input  wire logic              external_clock_input_mode, // Monitor runs without waiting for the start-up timer
  input  wire logic              doze_active,       // Reduced-rate CPU mode
  input  wire logic              sleep_enter,       // Sleep instruction pulse
  input  wire logic              wake,              // Wake from sleep pulse
  output clksw_pkg::osc_vec_t    osc_enable,        // Oscillator run requests
  output clksw_pkg::clk_sel_t    sys_clk_sel,       // Source and divider in use
  output logic                   sys_clk_halt,      // Clock stopped for PLL relock
  output logic                   hf_force_1mhz,     // Internal oscillator forced to 1 MHz
  output logic      [2:0]        hf_frequency_select, // Frequency select to oscillator
  output logic                   mf_derived_clock,  // Frozen-capable mid clock
  output logic                   switch_irq,        // Switch interrupt request
  output logic                   osc_fail_irq       // Oscillator fail interrupt request
);
  import clksw_pkg::*;

  // Register state
  clk_sel_t   req_q, cur_q;
  logic       hold_q, newrdy_q, swflag_q, failflag_q, swie_q, failie_q;
  osc_vec_t   men_q;
  logic [2:0] frq_q;
  logic       frq_pend_q, frq_low_q, hfrdy_q, mfrdy_q, mfclk_q;
  logic       sleep_q, fs_q;
  logic [10:0] ost_q;
  logic       ost_done_q, ext_d1_q, lf_d1_q, samp_q, latch_q;
  logic [4:0] lfcnt_q;
  sw_state_t  st_q;
  logic [31:0] rdata_q;

  // Bus decode
  wire [11:0] idx     = paddr[13:2];
  wire        setup   = psel && !penable;
  wire        wr      = psel && penable && pwrite;
  wire        hit_req = idx == `IDX_REQUEST;
  wire        hit_cur = idx == `IDX_CURRENT;
  wire        hit_ctl = idx == `IDX_SW_CTRL;
  wire        hit_sta = idx == `IDX_STATUS;
  wire        hit_en  = idx == `IDX_ENABLE;
  wire        hit_frq = idx == `IDX_FRQ_SEL;
  wire        hit_if  = idx == `IDX_IRQ_FLAG;
  wire        hit_ie  = idx == `IDX_IRQ_EN;
  wire        mapped  = hit_req || hit_cur || hit_ctl || hit_sta || hit_en || hit_frq || hit_if || hit_ie;
  wire [2:0]  wsrc    = pwdata[6:4];
  wire        src_ok  = wsrc != 3'h0 && wsrc != 3'h3;
  wire        req_wr  = wr && hit_req && src_ok && pwdata[3:0] <= `REQ_DIV_MAX;
  wire        frq_wr  = wr && hit_frq;

  // Status view: high/mid flags follow the frequency-change handshake
  osc_vec_t sta;
  assign sta = '{ext: osc_ready_in.ext && ost_done_q, hf: hfrdy_q, mf: mfrdy_q,
                 lf: osc_ready_in.lf, sec: osc_ready_in.sec, pll: osc_ready_in.pll};

  // Requested-source readiness; an already running source is ready at once
  wire is_ext_req = req_q.src == `SRC_EXT || req_q.src == `SRC_EXT_PLL || req_q.src == `SRC_SEC;
  wire is_ext_cur = cur_q.src == `SRC_EXT || cur_q.src == `SRC_EXT_PLL || cur_q.src == `SRC_SEC;
  wire cur_pll    = cur_q.src == `SRC_EXT_PLL || cur_q.src == `SRC_HF_PLL;
  wire req_pll    = req_q.src == `SRC_EXT_PLL || req_q.src == `SRC_HF_PLL;
  wire same_src   = req_q.src == cur_q.src && !fs_q;
  wire src_rdy    = (req_q.src == `SRC_EXT || req_q.src == `SRC_EXT_PLL) ? sta.ext :
                    (req_q.src == `SRC_SEC) ? osc_ready_in.sec && ost_done_q :
                    (req_q.src == `SRC_LF)  ? osc_ready_in.lf : osc_ready_in.hf;
  wire req_rdy    = same_src || src_rdy;
  wire pending    = req_q != cur_q || fs_q;
  wire pll_swap   = req_pll && cur_pll && req_q.src != cur_q.src;
  // Switch takes effect on the next pclk edge in run and doze alike, but not while asleep
  wire do_switch  = !sleep_q && ((st_q == SW_WAIT && req_rdy && !hold_q && !pll_swap) ||
                    (st_q == SW_HOLD && !hold_q && !pll_swap) ||
                    (st_q == SW_LOCK && osc_ready_in.pll));
  wire becomes_rdy = st_q == SW_WAIT && req_rdy && !sleep_q && pending;

  // Fail-safe sampling: edges of the external and low clocks
  wire ext_fall  = ext_d1_q && !ext_clk_in;
  wire lf_rise   = !lf_d1_q && lf_clk_in;
  wire samp_tick = lf_rise && lfcnt_q == 5'(`SAMPLE_DIV / 2 - 1);
  wire mon_on    = failsafe_enable_cfg && is_ext_cur && !fs_q && !sleep_q &&
                   (ost_done_q || external_clock_input_mode);
  wire fail_det  = mon_on && samp_tick && samp_q && (!latch_q || (cur_pll && !osc_ready_in.pll));
  wire ost_start = sleep_enter || (req_wr && wsrc != cur_q.src);

  // Request register: reserved writes leave it untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '{src: `RST_SRC, div: `RST_DIV};
    end else if (req_wr) begin
      req_q <= '{src: wsrc, div: pwdata[3:0]};
    end
  end

  // Current selection changes only at the switch or on a failure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= '{src: `RST_SRC, div: `RST_DIV};
    end else if (fail_det) begin
      cur_q <= '{src: `SRC_HF, div: `FS_DIV};
    end else if (do_switch || (wake && !hold_q && pending)) begin
      cur_q <= req_q;
    end
  end

  // Switch sequencer; a stale pending switch is dropped by sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SW_IDLE;
    end else if (sleep_enter) begin
      st_q <= SW_IDLE;
    end else begin
      case (st_q)
        SW_IDLE: if (pending && !sleep_q && !fail_det && !(fs_q && !req_wr)) begin
          st_q <= SW_WAIT;
        end
        SW_WAIT: if (do_switch || !pending) begin
          st_q <= SW_IDLE;
        end else if (req_rdy && !sleep_q) begin
          st_q <= hold_q ? SW_HOLD : SW_LOCK;
        end
        SW_HOLD: if (!pending) begin
          st_q <= SW_IDLE;
        end else if (do_switch) begin
          st_q <= SW_IDLE;
        end else if (!hold_q) begin
          st_q <= SW_LOCK;
        end
        SW_LOCK: if (do_switch || !pending) begin
          st_q <= SW_IDLE;
        end
        default: st_q <= SW_IDLE;
      endcase
    end
  end

  // New-ready bit, switch flag and hold bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      newrdy_q <= 1'b0;
      swflag_q <= 1'b0;
      hold_q   <= 1'b0;
    end else begin
      if (becomes_rdy) begin
        newrdy_q <= 1'b1;
      end else if (do_switch || !pending || sleep_enter) begin
        newrdy_q <= 1'b0;
      end
      // Set wins over a software clear in the same cycle; no hardware clear
      if (becomes_rdy || (wake && !hold_q && pending)) begin
        swflag_q <= 1'b1;
      end else if (wr && hit_if && pwdata[`IRQ_SWITCH]) begin
        swflag_q <= 1'b0;
      end
      if (wr && hit_ctl) begin
        hold_q <= pwdata[`CTL_HOLD];
      end else if (do_switch) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Fail-safe condition and fail flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_q       <= 1'b0;
      failflag_q <= 1'b0;
    end else begin
      if (fail_det) begin
        fs_q <= 1'b1;
      end else if (sleep_enter || (fs_q && do_switch)) begin
        fs_q <= 1'b0;
      end
      if (fail_det) begin
        failflag_q <= 1'b1;
      end else if (wr && hit_if && pwdata[`IRQ_OSCFAIL]) begin
        failflag_q <= 1'b0;
      end
    end
  end

  // Software registers: enables, interrupt enables, frequency select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      men_q    <= '0;
      swie_q   <= 1'b0;
      failie_q <= 1'b0;
      frq_q    <= `RST_FRQ;
    end else if (wr) begin
      if (hit_en) begin
        men_q <= '{ext: pwdata[7], hf: pwdata[6], mf: pwdata[5], lf: pwdata[4],
                   sec: pwdata[3], pll: 1'b0};
      end
      if (hit_ie) begin
        swie_q   <= pwdata[`IRQ_SWITCH];
        failie_q <= pwdata[`IRQ_OSCFAIL];
      end
      if (hit_frq) begin
        frq_q <= pwdata[2:0];
      end
    end
  end

  // Frequency change: flags drop, come back after the oscillator drops and returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frq_pend_q <= 1'b0;
      frq_low_q  <= 1'b0;
      hfrdy_q    <= 1'b0;
      mfrdy_q    <= 1'b0;
      mfclk_q    <= 1'b0;
    end else begin
      if (frq_wr) begin
        frq_pend_q <= 1'b1;
        frq_low_q  <= 1'b0;
      end else if (frq_pend_q && !osc_ready_in.hf) begin
        frq_low_q  <= 1'b1;
      end else if (frq_pend_q && frq_low_q && osc_ready_in.hf) begin
        frq_pend_q <= 1'b0;
      end
      hfrdy_q <= !frq_wr && !frq_pend_q && osc_ready_in.hf;
      mfrdy_q <= !frq_wr && !frq_pend_q && osc_ready_in.mf;
      // Holding the last level keeps the mid clock free of runt pulses
      mfclk_q <= (frq_pend_q || frq_wr) ? mfclk_q : mf_clk_in;
    end
  end

  // Start-up timer counts external falling edges after reset, wake or a new request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_q      <= '0;
      ost_done_q <= 1'b0;
    end else if (ost_start || wake) begin
      ost_q      <= '0;
      ost_done_q <= 1'b0;
    end else if (ext_fall && !ost_done_q) begin
      ost_q      <= ost_q + 11'h001;
      ost_done_q <= ost_q == 11'(`OST_CYCLES - 1);
    end
  end

  // Sample clock from the low clock and the fail latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_d1_q <= 1'b0;
      lf_d1_q  <= 1'b0;
      lfcnt_q  <= '0;
      samp_q   <= 1'b0;
      latch_q  <= 1'b0;
    end else begin
      ext_d1_q <= ext_clk_in;
      lf_d1_q  <= lf_clk_in;
      if (lf_rise) begin
        lfcnt_q <= samp_tick ? 5'h00 : lfcnt_q + 5'h01;
      end
      if (samp_tick) begin
        samp_q <= !samp_q;
      end
      // Sample rising edge clears, external falling edge sets
      if (samp_tick && !samp_q) begin
        latch_q <= 1'b0;
      end else if (ext_fall) begin
        latch_q <= 1'b1;
      end
    end
  end

  // Sleep tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (sleep_enter) begin
      sleep_q <= 1'b1;
    end else if (wake) begin
      sleep_q <= 1'b0;
    end
  end

  // Read data captured in the setup phase, presented in the access phase
  logic [31:0] rmux;
  assign rmux = hit_req ? {25'h0, req_q} :
                hit_cur ? {25'h0, cur_q} :
                hit_ctl ? {24'h0, hold_q, 2'b00, st_q == SW_IDLE && !pending, newrdy_q, 3'b000} :
                hit_sta ? {24'h0, sta.ext, sta.hf, sta.mf, sta.lf, sta.sec, 2'b00, sta.pll} :
                hit_en  ? {24'h0, men_q.ext, men_q.hf, men_q.mf, men_q.lf, men_q.sec, 3'b000} :
                hit_frq ? {29'h0, frq_q} :
                hit_if  ? {30'h0, failflag_q, swflag_q} :
                hit_ie  ? {30'h0, failie_q, swie_q} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      rdata_q <= rmux;
    end
  end

  // Outputs
  assign prdata              = rdata_q;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped;
  assign sys_clk_sel         = cur_q;
  assign sys_clk_halt        = st_q == SW_LOCK;
  assign hf_force_1mhz       = fs_q;
  assign hf_frequency_select = frq_q;
  assign mf_derived_clock    = mfclk_q;
  assign switch_irq          = swflag_q && swie_q;
  assign osc_fail_irq        = failflag_q && failie_q;
  assign osc_enable          = men_q | osc_vec_t'{ext: is_ext_cur || is_ext_req, hf: 1'b1, mf: 1'b1,
                                         lf: failsafe_enable_cfg || cur_q.src == `SRC_LF ||
                                         req_q.src == `SRC_LF, sec: cur_q.src == `SRC_SEC ||
                                         req_q.src == `SRC_SEC, pll: cur_pll || req_pll};

  // Checks
  sequence s_ready_hold;
    st_q == SW_WAIT && req_rdy && hold_q && !sleep_q && !sleep_enter;
  endsequence

  AST_RESERVED_SRC: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_req && !src_ok |=> $stable(req_q)) else $error("reserved source written");
  AST_DIV_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    req_q.div <= `REQ_DIV_MAX) else $error("divider out of range");
  AST_FLAGS_TOGETHER: assert property (@(posedge pclk) disable iff (!presetn)
    becomes_rdy |=> newrdy_q && swflag_q) else $error("new-ready and flag not set together");
  AST_HOLD_KEEPS_OLD: assert property (@(posedge pclk) disable iff (!presetn)
    s_ready_hold ##1 (hold_q && !fail_det) |=> $stable(cur_q)) else $error("switch under hold");
  AST_CUR_UPDATE: assert property (@(posedge pclk) disable iff (!presetn)
    do_switch && !fail_det |=> cur_q == $past(req_q) ##1 !newrdy_q) else $error("current not updated");
  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    swflag_q && !(wr && hit_if && pwdata[`IRQ_SWITCH]) |=> swflag_q) else $error("switch flag lost");
  AST_FAIL_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |=> cur_q.src == `SRC_HF && failflag_q && hf_force_1mhz) else $error("no fallback");
  AST_MF_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    frq_pend_q ##1 frq_pend_q |-> $stable(mf_derived_clock)) else $error("mid clock moved");
  AST_NO_MON_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |-> ost_done_q || external_clock_input_mode) else $error("monitor before timer");
endmodule : clock_switch_failsafe_monitor
